// file: rtl/psc_pkg.sv
package psc_pkg;
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned WIPER_BITS     = 10;
  localparam int unsigned WORD_BITS      = 16;
  localparam int unsigned STORE_WORDS    = 16;
  localparam int unsigned CMD_MSB        = 23;
  localparam int unsigned CMD_LSB        = 20;
  localparam int unsigned ADDR_MSB       = 19;
  localparam int unsigned ADDR_LSB       = 16;
  localparam logic [9:0]  WIPER_FULL     = 10'h3ff;
  localparam logic [9:0]  WIPER_MID      = 10'h200;
  localparam logic [9:0]  WIPER_ONE      = 10'h001;
  localparam logic [15:0] STORE_RST_WIPER = 16'h0200;
  localparam logic [15:0] STORE_RST_LATCH = 16'h0003;
  localparam logic [15:0] STORE_RST_USER  = 16'h0000;
  localparam logic [3:0]  ADDR_WIPER     = 4'h0;
  localparam logic [3:0]  ADDR_LATCH     = 4'h1;
  localparam int unsigned LATCH_ONE_BIT  = 0;
  localparam int unsigned LATCH_TWO_BIT  = 1;

  typedef enum logic [3:0] {
    CMD_NOP       = 4'h0,
    CMD_RESTORE   = 4'h1,
    CMD_STORE     = 4'h2,
    CMD_WRITE_NV  = 4'h3,
    CMD_HALVE     = 4'h4,
    CMD_HALVE_ANY = 4'h5,
    CMD_DEC       = 4'h6,
    CMD_DEC_ANY   = 4'h7,
    CMD_RESET     = 4'h8,
    CMD_READ_NV   = 4'h9,
    CMD_READ_WIPE = 4'ha,
    CMD_WRITE_WIP = 4'hb,
    CMD_DOUBLE    = 4'hc,
    CMD_DOUBLE_AN = 4'hd,
    CMD_INC       = 4'he,
    CMD_INC_ANY   = 4'hf
  } psc_cmd_e;
endpackage

// file: rtl/psc_link.sv
`timescale 1ns/1ps
`default_nettype none
// Link side: shift register on the serial clock, frame handed over on select rise
module psc_link (
  // Link pins
  input  wire logic                            link_clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            cs_n_i,
  input  wire logic                            sdi_i,
  output logic                                 sdo_o,
  output logic                                 sdo_oe_n_o,
  // Readback load, system domain, stable while select low
  input  wire logic                            rd_pend_i,
  input  wire logic [psc_pkg::WORD_BITS-1:0]   rd_word_i,
  // Frame result, stable after select rises
  output logic [psc_pkg::FRAME_BITS-1:0]       frame_o,
  output logic                                 frame_ok_o,
  output logic                                 frame_tgl_o
);
  import psc_pkg::*;

  logic [FRAME_BITS-1:0] shift_q;
  logic [7:0]            bits_q;
  logic                  tgl_q;
  logic                  ok_q;
  logic [FRAME_BITS-1:0] frame_q;

  // Shift in MSB first; first edge of a readback frame swaps in the word
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_q <= '0;
    end else if (!cs_n_i) begin
      if ((bits_q == 8'h00) && rd_pend_i) begin
        shift_q <= {shift_q[FRAME_BITS-2:WORD_BITS], rd_word_i, sdi_i};
      end else begin
        shift_q <= {shift_q[FRAME_BITS-2:0], sdi_i};
      end
    end
  end

  // Bit counter, cleared on select rise and held at zero while select is high
  always_ff @(posedge link_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bits_q <= '0;
    end else begin
      bits_q <= bits_q + 8'h01;
    end
  end

  // Frame capture on select rise
  always_ff @(posedge cs_n_i or posedge rst_i) begin
    if (rst_i) begin
      frame_q <= '0;
      ok_q    <= 1'b0;
      tgl_q   <= 1'b0;
    end else begin
      frame_q <= shift_q;
      ok_q    <= (bits_q[1:0] == 2'b00) && (bits_q != 8'h00);
      tgl_q   <= ~tgl_q;
    end
  end

  // Open drain, released while deselected
  assign sdo_o       = 1'b0;
  assign sdo_oe_n_o  = cs_n_i | shift_q[FRAME_BITS-1];
  assign frame_o     = frame_q;
  assign frame_ok_o  = ok_q;
  assign frame_tgl_o = tgl_q;
endmodule // psc_link
`default_nettype wire

// file: rtl/psc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module psc_decoder #(
  // Sizes
  parameter int unsigned WIPER_W = psc_pkg::WIPER_BITS,
  parameter int unsigned STORE_N = psc_pkg::STORE_WORDS
) (
  // System
  input  wire logic                            sys_clk_i,
  input  wire logic                            rst_i,
  // Serial link
  input  wire logic                            link_clk_i,
  input  wire logic                            cs_n_i,
  input  wire logic                            sdi_i,
  output logic                                 sdo_o,
  output logic                                 sdo_oe_n_o,
  // Device state
  output logic [psc_pkg::WIPER_BITS-1:0]       wiper_o,
  output logic                                 latched_output_one_o,
  output logic                                 latched_output_two_o,
  output logic                                 read_power_o
);
  import psc_pkg::*;

  // Sizes the logic can serve
  if (WIPER_W != WIPER_BITS) begin : g_bad_wiper
    $error("wiper width must match the port width");
  end
  if ((STORE_N < 2) || (STORE_N > STORE_WORDS)) begin : g_bad_store
    $error("store depth must be 2 to 16 words");
  end

  logic [FRAME_BITS-1:0] frame;
  logic                  frame_ok;
  logic                  frame_tgl;
  logic                  rd_pend_q;
  logic [WORD_BITS-1:0]  rd_word_q;

  psc_link u_link (
    .link_clk_i  (link_clk_i),
    .rst_i       (rst_i),
    .cs_n_i      (cs_n_i),
    .sdi_i       (sdi_i),
    .sdo_o       (sdo_o),
    .sdo_oe_n_o  (sdo_oe_n_o),
    .rd_pend_i   (rd_pend_q),
    .rd_word_i   (rd_word_q),
    .frame_o     (frame),
    .frame_ok_o  (frame_ok),
    .frame_tgl_o (frame_tgl)
  );

  // Toggle crossing of frame event
  logic [2:0] tgl_sync_q;
  logic       frame_evt;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_sync_q <= '0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl};
    end
  end
  assign frame_evt = tgl_sync_q[2] ^ tgl_sync_q[1];

  // Frame words are stable for many cycles once the toggle has crossed
  logic [FRAME_BITS-1:0] frame_q;
  logic                  ok_q;
  logic                  evt_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_q <= '0;
      ok_q    <= 1'b0;
      evt_q   <= 1'b0;
    end else begin
      evt_q <= frame_evt;
      if (frame_evt) begin
        frame_q <= frame;
        ok_q    <= frame_ok;
      end
    end
  end

  // Nonvolatile store
  logic [WORD_BITS-1:0]  nonvolatile_store_q [STORE_N];
  logic [WIPER_W-1:0]    wiper_register_q;
  logic [WIPER_W-1:0]    wiper_register_d;
  logic [3:0]            last_cmd_q;
  logic                  have_cmd_q;
  logic                  boot_q;
  logic                  read_power_q;

  logic [3:0]           cmd;
  logic [3:0]           addr;
  logic [WORD_BITS-1:0] data;
  logic                 exec;
  logic [3:0]           eff_cmd;

  assign cmd  = frame_q[CMD_MSB:CMD_LSB];
  assign addr = frame_q[ADDR_MSB:ADDR_LSB];
  assign data = frame_q[WORD_BITS-1:0];
  // One execution per crossed frame, none while the boot load runs
  assign exec    = evt_q && !boot_q;
  assign eff_cmd = last_cmd_q;

  // Saturating doubling, plain halving
  function automatic logic [WIPER_BITS-1:0] dbl(input logic [WIPER_BITS-1:0] v);
    if (v == '0) begin
      dbl = WIPER_ONE;
    end else if (v >= WIPER_MID) begin
      dbl = WIPER_FULL;
    end else begin
      dbl = {v[WIPER_BITS-2:0], 1'b0};
    end
  endfunction

  function automatic logic is_load(input logic [3:0] c);
    is_load = (c == CMD_RESTORE) || (c == CMD_RESET);
  endfunction

  // Current command: clean frame gives its own, a repeat uses the last
  logic       run;
  logic [3:0] run_cmd;
  logic       repeat_f;
  logic       frame_pulse_only_q;
  assign repeat_f = exec && !ok_q && have_cmd_q && frame_pulse_only_q;
  assign run      = (exec && ok_q) || repeat_f;
  assign run_cmd  = ok_q ? cmd : eff_cmd;

  // Empty pulse: no bits clocked, flagged as no-count frame
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_pulse_only_q <= 1'b0;
    end else if (frame_evt) begin
      frame_pulse_only_q <= !frame_ok && (frame == frame_q);
    end
  end

  // Wiper next value
  always_comb begin
    wiper_register_d = wiper_register_q;
    if (boot_q) begin
      wiper_register_d = nonvolatile_store_q[ADDR_WIPER][WIPER_BITS-1:0];
    end else if (run) begin
      case (psc_cmd_e'(run_cmd))
        CMD_NOP: ;
        CMD_RESTORE, CMD_RESET:
          wiper_register_d = nonvolatile_store_q[ADDR_WIPER][WIPER_BITS-1:0];
        CMD_HALVE, CMD_HALVE_ANY:
          wiper_register_d = {1'b0, wiper_register_q[WIPER_BITS-1:1]};
        CMD_DEC, CMD_DEC_ANY:
          if (wiper_register_q != '0) begin
            wiper_register_d = wiper_register_q - 10'h001;
          end
        CMD_WRITE_WIP:
          wiper_register_d = data[WIPER_BITS-1:0];
        CMD_DOUBLE, CMD_DOUBLE_AN:
          wiper_register_d = dbl(wiper_register_q);
        CMD_INC, CMD_INC_ANY:
          if (wiper_register_q != WIPER_FULL) begin
            wiper_register_d = wiper_register_q + 10'h001;
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wiper_register_q <= '0;
    end else begin
      wiper_register_q <= wiper_register_d;
    end
  end

  // Power-on load takes one cycle after reset release
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // Command history
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_cmd_q <= 4'h0;
      have_cmd_q <= 1'b0;
    end else if (exec && ok_q) begin
      last_cmd_q <= cmd;
      have_cmd_q <= 1'b1;
    end
  end

  // Store write decode: command 2 hits word zero, command 3 the addressed word
  function automatic logic nv_hit(input logic [3:0] c, input logic [3:0] a,
                                  input int unsigned idx);
    nv_hit = ((c == CMD_STORE) && (idx == 0)) ||
             ((c == CMD_WRITE_NV) && (a == 4'(idx)));
  endfunction

  // Store write data; word zero keeps the wiper bits only
  logic [WORD_BITS-1:0] nv_wdata;
  always_comb begin
    if (run_cmd == CMD_STORE) begin
      nv_wdata = {6'h00, wiper_register_q};
    end else if (addr == ADDR_WIPER) begin
      nv_wdata = {6'h00, data[WIPER_BITS-1:0]};
    end else begin
      nv_wdata = data;
    end
  end

  // Store words, reset to their shipped contents
  for (genvar gi = 0; gi < STORE_N; gi++) begin : g_store
    localparam logic [15:0] RST = (gi == 0) ? STORE_RST_WIPER :
                                  (gi == 1) ? STORE_RST_LATCH : STORE_RST_USER;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        nonvolatile_store_q[gi] <= RST;
      end else if (run && nv_hit(run_cmd, addr, gi)) begin
        nonvolatile_store_q[gi] <= nv_wdata;
      end
    end
  end

  // Latched outputs
  logic [1:0] latch_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= 2'b11;
    end else if (boot_q || (run && is_load(run_cmd))) begin
      latch_q <= {nonvolatile_store_q[ADDR_LATCH][LATCH_TWO_BIT],
                  nonvolatile_store_q[ADDR_LATCH][LATCH_ONE_BIT]};
    end
  end

  // Read power state, left by a nop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_power_q <= 1'b0;
    end else if (run && run_cmd == CMD_RESTORE) begin
      read_power_q <= 1'b1;
    end else if (run && run_cmd == CMD_NOP) begin
      read_power_q <= 1'b0;
    end
  end

  // Addressed store word, zero beyond the fitted depth
  logic [WORD_BITS-1:0] rd_nv;
  always_comb begin
    rd_nv = '0;
    for (int k = 0; k < STORE_N; k++) begin
      if (addr == 4'(k)) begin
        rd_nv = nonvolatile_store_q[k];
      end
    end
  end

  // Readback word for next frame
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pend_q <= 1'b0;
      rd_word_q <= '0;
    end else if (run) begin
      rd_pend_q <= 1'b0;
      if (run_cmd == CMD_READ_NV) begin
        rd_pend_q <= 1'b1;
        rd_word_q <= rd_nv;
      end else if (run_cmd == CMD_READ_WIPE) begin
        rd_pend_q <= 1'b1;
        rd_word_q <= {6'h00, wiper_register_q};
      end
    end
  end

  assign wiper_o              = wiper_register_q;
  assign latched_output_one_o = latch_q[0];
  assign latched_output_two_o = latch_q[1];
  assign read_power_o         = read_power_q;
endmodule // psc_decoder
`default_nettype wire

// file: bench/psc_decoder_props.sv
`timescale 1ns/1ps
`default_nettype none
module psc_decoder_props (
  // System
  input wire logic                          sys_clk_i,
  input wire logic                          rst_i,
  // Serial link
  input wire logic                          link_clk_i,
  input wire logic                          cs_n_i,
  input wire logic                          sdi_i,
  input wire logic                          sdo_o,
  input wire logic                          sdo_oe_n_o,
  // Device state
  input wire logic [psc_pkg::WIPER_BITS-1:0] wiper_o,
  input wire logic                          latched_output_one_o,
  input wire logic                          latched_output_two_o,
  input wire logic                          read_power_o
);
  import psc_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Reset release and the boot load after it
  sequence s_boot;
    $fell(rst_i);
  endsequence
  sequence s_loaded;
    ##[1:2] (wiper_o == STORE_RST_WIPER[9:0]);
  endsequence
  property p_boot_wiper;
    s_boot |-> s_loaded;
  endproperty
  a_boot_wiper: assert property (p_boot_wiper) else $error("wiper not loaded at boot");
  property p_boot_latch;
    s_boot |-> ##[1:2] (latched_output_one_o && latched_output_two_o);
  endproperty
  a_boot_latch: assert property (p_boot_latch) else $error("latches not one at boot");
  property p_sdo_idle;
    cs_n_i |-> sdo_oe_n_o;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("data out driven while idle");
  property p_sdo_low;
    !sdo_o;
  endproperty
  a_sdo_low: assert property (p_sdo_low) else $error("data out value not low");
  property p_wiper_exec;
    $changed(wiper_o) |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  a_wiper_exec: assert property (p_wiper_exec) else $error("wiper moved inside frame");
  property p_wiper_once;
    $changed(wiper_o) |=> $stable(wiper_o) [*2];
  endproperty
  a_wiper_once: assert property (p_wiper_once) else $error("wiper moved twice");
  property p_latch_exec;
    $changed({latched_output_one_o, latched_output_two_o}) |-> $past(cs_n_i, 2);
  endproperty
  a_latch_exec: assert property (p_latch_exec) else $error("latch moved inside frame");
  property p_rdpwr_exec;
    $changed(read_power_o) |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  a_rdpwr_exec: assert property (p_rdpwr_exec) else $error("power state moved in frame");
endmodule // psc_decoder_props
bind psc_decoder psc_decoder_props u_props (.sys_clk_i, .rst_i, .link_clk_i, .cs_n_i, .sdi_i,
  .sdo_o, .sdo_oe_n_o, .wiper_o, .latched_output_one_o, .latched_output_two_o, .read_power_o);
`default_nettype wire

// file: bench/psc_host.sv
`timescale 1ns/1ps
`default_nettype none
module psc_host (
  // Link pins
  output logic      link_clk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    link_clk_o = 1'b0;
    cs_n_o     = 1'b1;
    sdi_o      = 1'b0;
  end
  // Mode 0 frame, clock idles low, MSB first
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = 24'h00_0000;
    #7 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = tx[i];
      #15 rx = {rx[22:0], sdo_i};
      link_clk_o = 1'b1;
      #15 link_clk_o = 1'b0;
    end
    #15 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
endmodule // psc_host
`default_nettype wire

// file: bench/tb_psc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_psc_decoder;
  import psc_pkg::*;
  typedef struct packed {
    logic [23:0] rx;
    logic        rxv;
    logic [9:0]  w;
    logic [1:0]  lt;
    logic        rp;
  } psc_exp_s;
  logic                  sys_clk_i = 1'b0;
  logic                  rst_i     = 1'b1;
  wire logic             link_clk, cs_n, sdi, sdo, sdo_oe_n, lt1, lt2, rdpwr;
  wire logic [WIPER_BITS-1:0] wiper;
  // Pull-up on the open-drain line
  wire logic             sdo_w     = sdo_oe_n ? 1'b1 : sdo;
  int                    error_cnt = 0;
  int                    checked   = 0;
  int                    cyc       = 0;
  logic [31:0]           seed      = 32'h0000_001a;
  psc_exp_s              exp_q[$];
  event                  res_ev;
  logic [23:0]           got, ptx, r;
  logic [15:0]           st[16];
  logic [15:0]           rdw;
  logic [9:0]            w;
  logic [1:0]            lt;
  logic                  rp, pv, rdo;

  psc_decoder dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk_i(link_clk), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .wiper_o(wiper),
    .latched_output_one_o(lt1), .latched_output_two_o(lt2), .read_power_o(rdpwr));
  psc_host host (.link_clk_o(link_clk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_w));

  always #10 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic miss(input logic [23:0] e, input logic [23:0] g);
    error_cnt++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
  endtask
  task automatic cmp24(input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) miss(e, g);
  endtask
  task automatic cmp10(input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) miss(24'(e), 24'(g));
  endtask
  task automatic cmp1(input logic e, input logic g);
    checked++;
    if (g !== e) miss(24'(e), 24'(g));
  endtask

  task automatic mreset();
    foreach (st[i]) st[i] = STORE_RST_USER;
    st[0] = STORE_RST_WIPER;
    st[1] = STORE_RST_LATCH;
    w = st[0][9:0];
    lt = st[1][1:0];
    rp = 1'b0;
    pv = 1'b0;
    rdo = 1'b0;
    @(posedge sys_clk_i);
    #2 rst_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #2 rst_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask

  // One frame: drive, settle, note the expected state
  task automatic frame(input logic [23:0] tx, input int n = 24);
    psc_exp_s e;
    logic [23:0] f;
    host.xfer(tx, n, got);
    repeat (12) @(posedge sys_clk_i);
    e.rxv = pv && n == 24;
    e.rx = rdo ? {ptx[23:16], rdw} : ptx;
    rdo = 1'b0;
    f = (n == 0) ? ptx : tx;
    if (n % 4 == 0) begin
      case (f[23:20])
        4'h1, 4'h8: begin
          w = st[0][9:0];
          lt = st[1][1:0];
        end
        4'h2: st[0] = {6'h00, w};
        4'h3: st[f[19:16]] = (f[19:16] == ADDR_WIPER) ? {6'h00, f[9:0]} : f[15:0];
        4'h4, 4'h5: w = w >> 1;
        4'h6, 4'h7: w = (w == 10'h000) ? w : w - 10'h001;
        4'h9: rdw = st[f[19:16]];
        4'ha: rdw = {6'h00, w};
        4'hb: w = f[9:0];
        4'hc, 4'hd: w = (w == 10'h000) ? WIPER_ONE : (w >= WIPER_MID) ? WIPER_FULL : w << 1;
        4'he, 4'hf: w = (w == WIPER_FULL) ? w : w + 10'h001;
        default: ;
      endcase
      if (f[23:20] == 4'h0) rp = 1'b0;
      if (f[23:20] == 4'h1) rp = 1'b1;
      rdo = n != 0 && (f[23:20] == 4'h9 || f[23:20] == 4'ha);
    end
    if (n == 24) ptx = tx;
    pv = n == 24 || (n == 0 && pv);
    e.w = w;
    e.lt = lt;
    e.rp = rp;
    exp_q.push_back(e);
    -> res_ev;
  endtask

  always @(res_ev) begin : mon
    psc_exp_s e;
    e = exp_q.pop_front();
    if (e.rxv) cmp24(e.rx, got);
    cmp10(e.w, wiper);
    cmp1(e.lt[LATCH_ONE_BIT], lt1);
    cmp1(e.lt[LATCH_TWO_BIT], lt2);
    cmp1(e.rp, rdpwr);
  end

  task automatic conclude();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    mreset();
    frame(24'h05_abcd);
    frame(24'hb0_ffff);
    frame(24'he0_1234);
    frame(24'hb0_0000);
    frame(24'h60_5a5a);
    frame(24'hc0_0000);
    $display("test limits done");
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      frame({4'hb, 4'h0, r[15:0]});
      frame({i[2], 1'b1, i[1:0], i[0] ? r[19:16] : 4'h0, r[23:8]});
    end
    $display("test steps done");
    frame(24'hf0_0000);
    frame(24'h00_0000, 0);
    frame(24'hb0_0155, 22);
    frame(24'ha0_0000);
    frame(24'h00_0000);
    $display("test repeat done");
    for (int a = 2; a < 16; a++) begin
      r = rnd();
      frame({4'h3, a[3:0], r[15:0]});
    end
    for (int a = 15; a >= 0; a--) frame({4'h9, a[3:0], 16'h5555});
    frame(24'h00_0000);
    frame(24'h30_fd55);
    frame(24'h90_0000);
    frame(24'h80_0000);
    frame(24'h31_0002);
    frame(24'h10_0000);
    frame(24'h00_0000);
    frame(24'hb0_00ab);
    frame(24'h20_0000);
    frame(24'hb0_0000);
    frame(24'h8f_ffff);
    $display("test store done");
    mreset();
    frame(24'h00_0000);
    $display("test reset done");
    repeat (4) @(posedge sys_clk_i);
    conclude();
  end
endmodule // tb_psc_decoder
`default_nettype wire
